// ===== iasd_alu.sv
// integer alu and shift datapath top, one registered result stage
// assumes issue logic gives decoded operands read from the register file
`timescale 1ns/1ps
module iasd_alu
  import iasd_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire iasd_req_s req_in,
  output iasd_res_s res_out,
  output logic int_busy_out,
  output logic mem_busy_out
);
  function automatic logic [63:0] sext(input logic [21:0] imm,
                                       input int bits);
    logic [63:0] r;
    r = {{42{imm[21]}}, imm};
    if (bits == IASD_IMM15_W)
      r = {{49{imm[14]}}, imm[14:0]};
    else if (bits == IASD_IMM8_W)
      r = {{56{imm[7]}}, imm[7:0]};
    return r;
  endfunction : sext

  iasd_res_s res_reg, res_next;
  logic int_busy_reg, int_busy_next;
  logic mem_busy_reg, mem_busy_next;
  logic [63:0] a, b, opnd, sum_shl, fld_y, ptr_sum;
  logic [63:0] mask_cnt;
  logic big;
  logic illegal;

  iasd_field_unit u_field (
    .op_in(req_in.op),
    .a_in(a),
    .b_in(b),
    .pos_in(req_in.pos),
    .len_in(req_in.len),
    .dep_src_in(req_in.dep_src),
    .y_out(fld_y)
  );

  always_comb begin
    // register 0 reads zero
    a = (req_in.src1_idx == 7'h0) ? 64'h0 : req_in.src1;
    b = (req_in.src2_idx == 7'h0) ? 64'h0 : req_in.src2;
    // immediate stands as first operand
    opnd = a;
    // long add always carries its immediate
    if (req_in.use_imm || req_in.op == IASD_OP_ADDL)
      opnd = (req_in.op == IASD_OP_ADDL) ? sext(req_in.imm, IASD_IMM22_W) :
             (req_in.op == IASD_OP_ADD || req_in.op == IASD_OP_SUB ||
              req_in.op == IASD_OP_ADDP) ? sext(req_in.imm, IASD_IMM15_W) :
             sext(req_in.imm, IASD_IMM8_W);
    sum_shl = (a << req_in.shl_count) + b;
    ptr_sum = (req_in.op == IASD_OP_SHLADDP) ? sum_shl : opnd + b;
    big = b[63:6] != 58'h0;
    mask_cnt = 64'(b[5:0]);
    illegal = 1'b0;
    // source of the long form must be register 0..3
    if (req_in.op == IASD_OP_ADDL && req_in.src2_idx > 7'h3)
      illegal = 1'b1;
    if ((req_in.op == IASD_OP_SHLADD || req_in.op == IASD_OP_SHLADDP) &&
        (req_in.shl_count < IASD_SHL_MIN || req_in.shl_count > IASD_SHL_MAX))
      illegal = 1'b1;
    if (req_in.op == IASD_OP_SHLADDP && req_in.use_imm)
      illegal = 1'b1;
    if ((req_in.op == IASD_OP_EXTR || req_in.op == IASD_OP_EXTRU ||
         req_in.op == IASD_OP_DEP || req_in.op == IASD_OP_DEPZ) &&
        // eight bits so a long field cannot wrap past the check
        (8'(req_in.pos) + 8'(req_in.len) > 8'd64 || req_in.len == 7'h0))
      illegal = 1'b1;

    res_next = '0;
    res_next.valid = req_in.valid;
    res_next.dest_idx = req_in.dest_idx;
    res_next.illegal = req_in.valid && illegal;
    case (req_in.op)
      IASD_OP_ADD, IASD_OP_ADDL: res_next.value = opnd + b;
      IASD_OP_ADD1: res_next.value = a + b + 64'h1;
      IASD_OP_SUB: res_next.value = opnd - b;
      IASD_OP_SUB1: res_next.value = a - b - 64'h1;
      IASD_OP_SHLADD: res_next.value = sum_shl;
      IASD_OP_AND: res_next.value = opnd & b;
      IASD_OP_OR: res_next.value = opnd | b;
      IASD_OP_XOR: res_next.value = opnd ^ b;
      IASD_OP_ANDCM: res_next.value = opnd & ~b;
      IASD_OP_ADDP, IASD_OP_SHLADDP: begin
        res_next.value = {32'h0, ptr_sum[31:0]};
        res_next.value[IASD_PTR_DST_LO +: 2] =
          b[IASD_PTR_SRC_LO +: 2];
      end
      IASD_OP_SXT: begin
        case (req_in.size)
          IASD_SZ_8: res_next.value = {{56{a[7]}}, a[7:0]};
          IASD_SZ_16: res_next.value = {{48{a[15]}}, a[15:0]};
          default: res_next.value = {{32{a[31]}}, a[31:0]};
        endcase
      end
      IASD_OP_ZXT: begin
        case (req_in.size)
          IASD_SZ_8: res_next.value = {56'h0, a[7:0]};
          IASD_SZ_16: res_next.value = {48'h0, a[15:0]};
          default: res_next.value = {32'h0, a[31:0]};
        endcase
      end
      // count from second register
      IASD_OP_SHR: res_next.value = big ? {64{a[63]}} :
                     64'($signed(a) >>> mask_cnt[5:0]);
      IASD_OP_SHRU: res_next.value = big ? 64'h0 :
                      a >> mask_cnt[5:0];
      IASD_OP_SHL: res_next.value = big ? 64'h0 :
                     a << mask_cnt[5:0];
      IASD_OP_EXTR, IASD_OP_EXTRU, IASD_OP_DEP, IASD_OP_DEPZ,
      IASD_OP_SHRP: res_next.value = fld_y;
      default: res_next.value = 64'h0;
    endcase
    // both unit classes execute every op
    int_busy_next = req_in.valid && req_in.unit == IASD_UNIT_INT;
    mem_busy_next = req_in.valid && req_in.unit == IASD_UNIT_MEM;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      res_reg <= '0;
      int_busy_reg <= 1'b0;
      mem_busy_reg <= 1'b0;
    end else begin
      res_reg <= res_next;
      int_busy_reg <= int_busy_next;
      mem_busy_reg <= mem_busy_next;
    end
  end

  assign res_out = res_reg;
  assign int_busy_out = int_busy_reg;
  assign mem_busy_out = mem_busy_reg;

  property p_add1;
    @(posedge clk_in) disable iff (!reset_n_in)
      req_in.valid && req_in.op == IASD_OP_ADD1 |=>
      res_out.value == $past(a) + $past(b) + 64'h1;
  endproperty
  a_add1: assert property (p_add1) else $error("add1 wrong");

  property p_sub1;
    @(posedge clk_in) disable iff (!reset_n_in)
      req_in.valid && req_in.op == IASD_OP_SUB1 |=>
      res_out.value + 64'h1 == $past(a) - $past(b);
  endproperty
  a_sub1: assert property (p_sub1) else $error("sub1 wrong");

  property p_addl_src;
    @(posedge clk_in) disable iff (!reset_n_in)
      req_in.valid && req_in.op == IASD_OP_ADDL && req_in.src2_idx > 7'h3
      |=> res_out.illegal;
  endproperty
  a_addl_src: assert property (p_addl_src)
    else $error("long add src");

  property p_ptr;
    @(posedge clk_in) disable iff (!reset_n_in)
      req_in.valid && req_in.op == IASD_OP_ADDP |=>
      res_out.value[63] == 1'b0 && res_out.value[60:32] == 29'h0 &&
      res_out.value[62:61] == $past(b[31:30]);
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer sum wrong");

  property p_r0;
    @(posedge clk_in) disable iff (!reset_n_in)
      req_in.valid && req_in.op == IASD_OP_OR && !req_in.use_imm &&
      req_in.src1_idx == 7'h0 && req_in.src2_idx == 7'h0
      |=> res_out.value == 64'h0;
  endproperty
  a_r0: assert property (p_r0)
    else $error("register 0 not zero");

  property p_shr_big;
    @(posedge clk_in) disable iff (!reset_n_in)
      req_in.valid && req_in.op == IASD_OP_SHR && b[63:6] != 58'h0
      |=> res_out.value == {64{$past(a[63])}};
  endproperty
  a_shr_big: assert property (p_shr_big) else $error("big sra");

  property p_rot;
    @(posedge clk_in) disable iff (!reset_n_in)
      req_in.valid && req_in.op == IASD_OP_SHRP && a == b
      |=> res_out.value == (($past(a) >> $past(req_in.pos)) |
                            ($past(a) << (7'd64 - 7'($past(req_in.pos)))));
  endproperty
  a_rot: assert property (p_rot) else $error("rotate wrong");

  property p_shladd;
    @(posedge clk_in) disable iff (!reset_n_in)
      req_in.valid && req_in.op == IASD_OP_SHLADD && req_in.shl_count == 3'h4
      |=> res_out.value == $past(a) * 64'h10 + $past(b);
  endproperty
  a_shladd: assert property (p_shladd)
    else $error("shladd wrong");

  property p_sub_imm;
    @(posedge clk_in) disable iff (!reset_n_in)
      req_in.valid && req_in.op == IASD_OP_SUB && req_in.use_imm |=>
      res_out.value == {{49{$past(req_in.imm[14])}},
                        $past(req_in.imm[14:0])} - $past(b);
  endproperty
  a_sub_imm: assert property (p_sub_imm)
    else $error("immediate sub wrong");

  property p_andcm;
    @(posedge clk_in) disable iff (!reset_n_in)
      req_in.valid && req_in.op == IASD_OP_ANDCM && !req_in.use_imm |=>
      (res_out.value & $past(b)) == 64'h0 &&
      (res_out.value | ~$past(a)) == (~$past(a) | ~$past(b));
  endproperty
  a_andcm: assert property (p_andcm)
    else $error("and with inverted wrong");

  property p_sxt8;
    @(posedge clk_in) disable iff (!reset_n_in)
      req_in.valid && req_in.op == IASD_OP_SXT && req_in.size == IASD_SZ_8
      |=> res_out.value[63:7] == {57{$past(a[7])}} &&
      res_out.value[6:0] == $past(a[6:0]);
  endproperty
  a_sxt8: assert property (p_sxt8)
    else $error("byte sign extension wrong");

  property p_zxt16;
    @(posedge clk_in) disable iff (!reset_n_in)
      req_in.valid && req_in.op == IASD_OP_ZXT && req_in.size == IASD_SZ_16
      |=> res_out.value[63:16] == 48'h0 &&
      res_out.value[15:0] == $past(a[15:0]);
  endproperty
  a_zxt16: assert property (p_zxt16)
    else $error("half zero extension wrong");

  property p_shr_sign;
    @(posedge clk_in) disable iff (!reset_n_in)
      req_in.valid && req_in.op == IASD_OP_SHR && a[63]
      |=> res_out.value[63];
  endproperty
  a_shr_sign: assert property (p_shr_sign)
    else $error("arithmetic shift lost sign");

  property p_shru_fill;
    @(posedge clk_in) disable iff (!reset_n_in)
      req_in.valid && req_in.op == IASD_OP_SHRU && b != 64'h0
      |=> !res_out.value[63];
  endproperty
  a_shru_fill: assert property (p_shru_fill)
    else $error("logical shift filled ones");

  property p_shl_one;
    @(posedge clk_in) disable iff (!reset_n_in)
      req_in.valid && req_in.op == IASD_OP_SHL && b == 64'h1
      |=> res_out.value == {$past(a[62:0]), 1'b0};
  endproperty
  a_shl_one: assert property (p_shl_one)
    else $error("left shift wrong");

  property p_shl_big;
    @(posedge clk_in) disable iff (!reset_n_in)
      req_in.valid && req_in.op == IASD_OP_SHL && b[63:6] != 58'h0
      |=> res_out.value == 64'h0;
  endproperty
  a_shl_big: assert property (p_shl_big)
    else $error("big left shift not zero");

  property p_extru;
    @(posedge clk_in) disable iff (!reset_n_in)
      req_in.valid && req_in.op == IASD_OP_EXTRU |=> res_out.illegal ||
      (res_out.value >> $past(req_in.len)) == 64'h0;
  endproperty
  a_extru: assert property (p_extru)
    else $error("unsigned extract upper bits set");

  property p_depz;
    @(posedge clk_in) disable iff (!reset_n_in)
      req_in.valid && req_in.op == IASD_OP_DEPZ |=> res_out.illegal ||
      (((res_out.value >> $past(req_in.pos)) >> $past(req_in.len)) ==
       64'h0 &&
       (res_out.value << (7'd64 - 7'($past(req_in.pos)))) == 64'h0);
  endproperty
  a_depz: assert property (p_depz)
    else $error("zero deposit kept outside bits");

  property p_unit;
    @(posedge clk_in) disable iff (!reset_n_in)
      req_in.valid && req_in.unit == IASD_UNIT_MEM
      |=> mem_busy_out && !int_busy_out;
  endproperty
  a_unit: assert property (p_unit)
    else $error("memory unit flag wrong");
endmodule : iasd_alu

// ===== iasd_field_unit.sv
// field extract, deposit and funnel shift unit, purely combinational
// assumes pos plus len already checked by the caller for range
`timescale 1ns/1ps
module iasd_field_unit
  import iasd_pkg::*;
(
  input wire iasd_op_e op_in,
  input wire logic [63:0] a_in,
  input wire logic [63:0] b_in,
  input wire logic [5:0] pos_in,
  input wire logic [6:0] len_in,
  input wire iasd_dsrc_e dep_src_in,
  output logic [63:0] y_out
);
  function automatic logic [63:0] low_mask(input logic [6:0] len);
    logic [127:0] t;
    t = (128'h1 << len) - 128'h1;
    return t[63:0];
  endfunction : low_mask

  logic [63:0] fmask;
  logic [63:0] field;
  logic [63:0] ext;
  logic [127:0] pair;
  logic [63:0] dsrc;
  logic [6:0] top;

  always_comb begin
    fmask = low_mask(len_in);
    top = 7'(pos_in) + len_in - 7'h1;
    field = (a_in >> pos_in) & fmask;
    ext = field;
    pair = {a_in, b_in} >> pos_in;
    dsrc = a_in;
    y_out = 64'h0;
    case (op_in)
      IASD_OP_EXTR: begin
        // sign of the field fills above it
        if (len_in != 7'h0 && a_in[top[5:0]])
          ext = field | ~fmask;
        y_out = ext;
      end
      IASD_OP_EXTRU: y_out = field;
      IASD_OP_DEP, IASD_OP_DEPZ: begin
        case (dep_src_in)
          IASD_DSRC_ZEROS: dsrc = 64'h0;
          IASD_DSRC_ONES: dsrc = 64'hFFFF_FFFF_FFFF_FFFF;
          default: dsrc = a_in;
        endcase
        if (op_in == IASD_OP_DEPZ)
          y_out = (dsrc & fmask) << pos_in;
        else
          y_out = ((dsrc & fmask) << pos_in) |
                  (b_in & ~(fmask << pos_in));
      end
      // same register twice rotates
      IASD_OP_SHRP: y_out = pair[63:0];
      default: y_out = 64'h0;
    endcase
  end
endmodule : iasd_field_unit

// ===== iasd_issue_model.sv
// issue logic model: drives decoded requests into the alu datapath
// assumes the bench calls issue just after a rising clock edge
`timescale 1ns/1ps
module iasd_issue_model
  import iasd_pkg::*;
(
  input wire logic clk_in,
  output iasd_req_s req_out
);
  iasd_req_s hold;
  initial req_out = '0;
  // request stands for one taking edge
  task automatic issue(input iasd_req_s r);
    if (r.op == IASD_OP_ADDL) r.src2_idx[6:2] = 5'h00;
    hold = r;
    req_out = r;
    @(posedge clk_in);
    #1;
  endtask : issue
  // idle bus shows no stale operands
  task automatic idle();
    hold = ~hold;
    hold.valid = 1'b0;
    req_out = hold;
    @(posedge clk_in);
    #1;
  endtask : idle
endmodule : iasd_issue_model

// ===== iasd_pkg.sv
// package for the integer alu and shift datapath: opcodes, request carrier
// assumes one core clock; issue logic supplies decoded operands
// Operation
// - add with constant-one third operand gives a plus b plus one
// - sub with constant-one third operand gives a minus b minus one
// - add and sub take a 15-bit immediate as first operand
// - add 22-bit immediate; issue picks source register 0 to 3 only
// - shift-then-sum shifts one operand left 1 to 4, adds other
// - and, or, xor between registers or register and immediate
// - and-with-inverted ands operand with complement of a register
// - pointer sum zeroes upper half, copies b bits 31:30 to 62:61
// - shifted pointer sum shifts first source 1 to 4, registers only
// - sign and zero extension of 8, 16 or 32 bit values
// - variable shifts take count from a second general register
// - arithmetic right fills with sign, logical right fills zero
// - left shift moves bits toward the most significant end
// - extract copies field to low bits, fills with sign or zero
// - fixed right shift is an extract reaching the top bit
// - deposit places field from register or all-zero/one immediate
// - zero deposit clears outside field; fixed left shift uses it
// - funnel shift takes 64-bit slice of 128-bit concatenation
// - funnel shift of same register twice gives rotation
// - arithmetic, logic, pointer ops run on integer and memory units
// - immediates are sign extended to 64 bits unless stated
// - general register 0 always reads as zero
package iasd_pkg;
  localparam int IASD_W = 64;
  localparam int IASD_IMM15_W = 15;
  localparam int IASD_IMM22_W = 22;
  localparam int IASD_IMM8_W = 8;
  localparam logic [63:0] IASD_RESULT_RESET = 64'h0;
  localparam logic [1:0] IASD_ADDR_RESET = 2'h0;
  localparam int IASD_PTR_SRC_LO = 30;
  localparam int IASD_PTR_DST_LO = 61;
  localparam logic [2:0] IASD_SHL_MIN = 3'h1;
  localparam logic [2:0] IASD_SHL_MAX = 3'h4;
  localparam int IASD_PIPE_LATENCY = 1;

  typedef enum logic [4:0] {
    IASD_OP_ADD, IASD_OP_ADD1, IASD_OP_SUB, IASD_OP_SUB1, IASD_OP_ADDL,
    IASD_OP_SHLADD, IASD_OP_AND, IASD_OP_OR, IASD_OP_XOR, IASD_OP_ANDCM,
    IASD_OP_ADDP, IASD_OP_SHLADDP, IASD_OP_SXT, IASD_OP_ZXT,
    IASD_OP_SHR, IASD_OP_SHRU, IASD_OP_SHL, IASD_OP_EXTR, IASD_OP_EXTRU,
    IASD_OP_DEP, IASD_OP_DEPZ, IASD_OP_SHRP
  } iasd_op_e;

  typedef enum logic [1:0] {
    IASD_SZ_8, IASD_SZ_16, IASD_SZ_32
  } iasd_size_e;

  typedef enum logic [1:0] {
    IASD_DSRC_REG, IASD_DSRC_ZEROS, IASD_DSRC_ONES
  } iasd_dsrc_e;

  typedef enum logic {
    IASD_UNIT_INT, IASD_UNIT_MEM
  } iasd_unit_e;

  // one issued operation
  typedef struct packed {
    logic valid;
    iasd_op_e op;
    iasd_unit_e unit;
    logic [6:0] src1_idx;
    logic [6:0] src2_idx;
    logic [63:0] src1;
    logic [63:0] src2;
    logic use_imm;
    logic [21:0] imm;
    logic [2:0] shl_count;
    logic [5:0] pos;
    logic [6:0] len;
    iasd_size_e size;
    iasd_dsrc_e dep_src;
    logic [6:0] dest_idx;
  } iasd_req_s;

  typedef struct packed {
    logic valid;
    logic [6:0] dest_idx;
    logic [63:0] value;
    logic illegal;
  } iasd_res_s;
endpackage : iasd_pkg

// ===== tb_integer_alu_shift_datapath.sv
// self-checking bench for the integer alu and shift datapath
// assumes one core clock and the issue model in front of the datapath
`timescale 1ns/1ps
module tb_integer_alu_shift_datapath
  import iasd_pkg::*;
;
  localparam logic [63:0] A_V = 64'hF00D_8421_C3A5_7E81;
  localparam logic [63:0] B_V = 64'h5555_AAAA_5555_AAAA;
  logic clk_in;
  logic reset_n_in;
  iasd_req_s req_w;
  iasd_res_s res_out;
  logic int_busy_out;
  logic mem_busy_out;
  iasd_req_s q;
  int miscompares = 0;
  int num_checks = 0;

  iasd_issue_model ISS (.clk_in(clk_in), .req_out(req_w));
  iasd_alu DUT (.clk_in(clk_in), .reset_n_in(reset_n_in), .req_in(req_w),
    .res_out(res_out), .int_busy_out(int_busy_out),
    .mem_busy_out(mem_busy_out));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  function automatic logic bad(iasd_req_s r);
    return r.op inside {IASD_OP_EXTR, IASD_OP_EXTRU, IASD_OP_DEP,
      IASD_OP_DEPZ} && (r.len == 0 || r.pos + r.len > 64);
  endfunction : bad

  function automatic logic [63:0] ref_val(iasd_req_s r);
    logic [63:0] a, b, s, m, f;
    int sz;
    a = (r.src1_idx == 7'h00) ? 64'h0 : r.src1;
    b = (r.src2_idx == 7'h00) ? 64'h0 : r.src2;
    if (r.op == IASD_OP_ADDL) a = {{42{r.imm[21]}}, r.imm};
    else if (r.use_imm && r.op inside {IASD_OP_AND, IASD_OP_OR,
        IASD_OP_XOR, IASD_OP_ANDCM}) a = {{56{r.imm[7]}}, r.imm[7:0]};
    else if (r.use_imm) a = {{49{r.imm[14]}}, r.imm[14:0]};
    sz = 8 << r.size;
    s = ((r.op == IASD_OP_SHLADDP) ? a << r.shl_count : a) + b;
    m = ((64'h1 << r.len) - 64'h1) << r.pos;
    f = (r.dep_src == IASD_DSRC_REG) ? a :
      {64{r.dep_src == IASD_DSRC_ONES}};
    case (r.op)
      IASD_OP_ADD, IASD_OP_ADDL: return a + b;
      IASD_OP_ADD1: return a + b + 64'h1;
      IASD_OP_SUB: return a - b;
      IASD_OP_SUB1: return a - b - 64'h1;
      IASD_OP_SHLADD: return (a << r.shl_count) + b;
      IASD_OP_AND: return a & b;
      IASD_OP_OR: return a | b;
      IASD_OP_XOR: return a ^ b;
      IASD_OP_ANDCM: return a & ~b;
      IASD_OP_ADDP, IASD_OP_SHLADDP: return {1'b0, b[31:30], 29'h0, s[31:0]};
      IASD_OP_SXT: return $signed(a << (64 - sz)) >>> (64 - sz);
      IASD_OP_ZXT: return (a << (64 - sz)) >> (64 - sz);
      IASD_OP_SHR: return $signed(a) >>> b;
      IASD_OP_SHRU: return a >> b;
      IASD_OP_SHL: return a << b;
      IASD_OP_EXTR: return $signed(a << (64 - r.pos - r.len)) >>> (64 - r.len);
      IASD_OP_EXTRU: return (a << (64 - r.pos - r.len)) >> (64 - r.len);
      IASD_OP_DEP: return ((f << r.pos) & m) | (b & ~m);
      IASD_OP_DEPZ: return (f << r.pos) & m;
      IASD_OP_SHRP: return 64'({a, b} >> r.pos);
      default: return 64'h0;
    endcase
  endfunction : ref_val

  task automatic set(input iasd_op_e op, input logic [63:0] a, b);
    q = '0;
    q.valid = 1'b1;
    q.op = op;
    q.src1 = a;
    q.src2 = b;
    q.src1_idx = 7'h05;
    q.src2_idx = 7'h06;
    q.dest_idx = 7'h2A;
    q.shl_count = 3'h1;
    q.len = 7'h01;
  endtask : set

  task automatic judge();
    chk(res_out.valid, 1'b1);
    chk(res_out.dest_idx, q.dest_idx);
    chk(res_out.illegal, bad(q));
    if (!bad(q)) chk(res_out.value, ref_val(q));
    chk(int_busy_out, q.unit == IASD_UNIT_INT);
    chk(mem_busy_out, q.unit == IASD_UNIT_MEM);
  endtask : judge

  task automatic run();
    ISS.issue(q);
    judge();
    ISS.idle();
  endtask : run

  task automatic t_arith();
    set(IASD_OP_ADD1, '1, 64'h1);
    run();
    set(IASD_OP_SUB1, 64'h0, 64'h0);
    run();
    q.op = IASD_OP_SUB;
    q.use_imm = 1'b1;
    q.imm = 22'h004000;
    run();
    q.op = IASD_OP_ADD;
    run();
    set(IASD_OP_ADDL, 64'h0, 64'hFFFF);
    q.src2_idx = 7'h03;
    q.imm = 22'h200001;
    run();
    q.src2_idx = 7'h00;
    run();
    set(IASD_OP_OR, A_V, B_V);
    q.src1_idx = 7'h00;
    q.src2_idx = 7'h00;
    run();
    for (int i = 1; i <= 4; i++) begin
      set(IASD_OP_SHLADD, 64'h8000_0000_0000_0001, 64'h3);
      q.shl_count = i[2:0];
      run();
    end
  endtask : t_arith

  task automatic t_logic();
    iasd_op_e ops [4] = '{IASD_OP_AND, IASD_OP_OR, IASD_OP_XOR, IASD_OP_ANDCM};
    for (int i = 0; i < 8; i++) begin
      set(ops[i % 4], A_V, B_V);
      q.use_imm = i[2];
      q.imm = 22'h000081;
      q.unit = i[0] ? IASD_UNIT_MEM : IASD_UNIT_INT;
      run();
    end
  endtask : t_logic

  task automatic t_ptr();
    set(IASD_OP_ADDP, A_V, 64'h1234_5678_4FFF_FFFF);
    q.unit = IASD_UNIT_MEM;
    run();
    q.use_imm = 1'b1;
    q.imm = 22'h007FFF;
    run();
    set(IASD_OP_SHLADDP, 64'h4000_0003, 64'hC000_0000);
    q.shl_count = 3'h4;
    run();
    for (int i = 0; i < 6; i++) begin
      set(iasd_op_e'(IASD_OP_SXT + i / 3), 64'h1234_5678_8000_8080, B_V);
      q.size = iasd_size_e'(i % 3);
      run();
    end
  endtask : t_ptr

  task automatic t_shift();
    logic [63:0] c [5] = '{64'h0, 64'h1, 64'h3F, 64'h40, 64'h1_0000_0001};
    for (int i = 0; i < 15; i++) begin
      set(iasd_op_e'(IASD_OP_SHR + i / 5), 64'h8123_4567_89AB_CDEF, c[i % 5]);
      run();
    end
  endtask : t_shift

  task automatic t_field();
    int pl [7][2] = '{'{0, 64}, '{4, 8}, '{60, 4}, '{3, 61}, '{1, 1},
      '{60, 5}, '{9, 0}};
    for (int i = 0; i < 28; i++) begin
      set(iasd_op_e'(IASD_OP_EXTR + i / 7), A_V, B_V);
      q.pos = pl[i % 7][0][5:0];
      q.len = pl[i % 7][1][6:0];
      q.dep_src = iasd_dsrc_e'(i % 3);
      run();
    end
  endtask : t_field

  task automatic t_pair();
    for (int p = 0; p < 64; p += 21) begin
      set(IASD_OP_SHRP, A_V, B_V);
      q.pos = p[5:0];
      run();
      q.src2_idx = q.src1_idx;
      q.src2 = A_V;
      run();
    end
  endtask : t_pair

  task automatic t_b2b();
    set(IASD_OP_SUB, 64'h10, 64'h11);
    ISS.issue(q);
    judge();
    set(IASD_OP_XOR, A_V, B_V);
    q.unit = IASD_UNIT_MEM;
    ISS.issue(q);
    judge();
    ISS.idle();
    chk(res_out.valid, 1'b0);
  endtask : t_b2b

  // reset in mid-run clears the result stage, then work resumes
  task automatic t_reset();
    set(IASD_OP_ADD, A_V, B_V);
    ISS.issue(q);
    judge();
    reset_n_in = 1'b0;
    ISS.idle();
    chk(res_out.valid, 1'b0);
    chk(res_out.value, 64'h0);
    chk(int_busy_out, 1'b0);
    reset_n_in = 1'b1;
    run();
  endtask : t_reset

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // about 170 cycles expected; ample margin
  initial begin
    #50000;
    miscompares++;
    wrap_up();
  end

  initial begin
    reset_n_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    reset_n_in = 1'b1;
    chk(res_out.valid, 1'b0);
    t_arith();
    t_logic();
    t_ptr();
    t_shift();
    t_field();
    t_pair();
    t_b2b();
    t_reset();
    wrap_up();
  end
endmodule : tb_integer_alu_shift_datapath
